// File: hw/pfl_pkg.sv
// constants, carrier types and decode helpers of the fault limit monitor
// What this block does
// - hold output current warning limit; current above it latches alert low
// - hold temperature fault limit; above it latches alert low and applies response
// - compare limits and act only once initialization has completed
// - temperature response 11 turns output off at least 3 s, recovers 5 C below
// - turn-off latch cleared by ctrl pin, operation command, both cycled, or power
// - hold temperature warning limit; above it latches alert low, no shutdown
// - hold input over-voltage fault limit; above it latches alert, applies response
// - over-voltage response 11 turns output off, restarts 5 V below limit
// - hold input over-voltage warning limit; above it latches alert low
// - hold input under-voltage warning limit; below it latches alert low
// - hold input under-voltage fault limit; below it latches alert, turns off
// - under-voltage fault limit written below turn-on minus 2 V is raised to that
// - effective under-voltage point is larger of fault limit and turn-off threshold
// - response registers take byte transfers, limit registers word transfers
// - response bits 5:3 give 1 to 64 restart attempts, 111 retries forever
// - response bits 2:0 give 1 to 128 delay units of 100 ms
package pfl_pkg;
  // register codes
  localparam logic [7:0] OFS_OC_WARN = 8'h4a;
  localparam logic [7:0] OFS_OT_FAULT = 8'h4f;
  localparam logic [7:0] OFS_OT_ACT = 8'h50;
  localparam logic [7:0] OFS_OT_WARN = 8'h51;
  localparam logic [7:0] OFS_OV_FAULT = 8'h55;
  localparam logic [7:0] OFS_OV_ACT = 8'h56;
  localparam logic [7:0] OFS_OV_WARN = 8'h57;
  localparam logic [7:0] OFS_UV_WARN = 8'h58;
  localparam logic [7:0] OFS_UV_FAULT = 8'h59;
  // reset values
  localparam logic [15:0] RST_HIGH_LIMIT = 16'h7bff;
  localparam logic [15:0] RST_LOW_LIMIT = 16'h0000;
  localparam logic [7:0] RST_ACTION = 8'h00;
  // response byte fields
  localparam int ACT_MODE_HI = 7;
  localparam int ACT_MODE_LO = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam logic [1:0] MODE_IGNORE = 2'h0;
  localparam logic [1:0] MODE_RUNON = 2'h1;
  localparam logic [1:0] MODE_HICCUP = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [7:0] UV_ACT = 8'hc0;
  // flag positions
  localparam int NUM_FLAGS = 7;
  localparam int FLG_OC_WARN = 0;
  localparam int FLG_OT_FAULT = 1;
  localparam int FLG_OT_WARN = 2;
  localparam int FLG_OV_FAULT = 3;
  localparam int FLG_OV_WARN = 4;
  localparam int FLG_UV_WARN = 5;
  localparam int FLG_UV_FAULT = 6;
  // fault causes
  localparam logic [1:0] CAUSE_OT = 2'h0;
  localparam logic [1:0] CAUSE_OV = 2'h1;
  localparam logic [1:0] CAUSE_UV = 2'h2;
  // fixed point: linear11 values scaled by 2^16
  localparam int FIX_FRAC = 16;
  localparam int MARGIN_OT_C = 5;
  localparam int MARGIN_OV_V = 5;
  localparam int UV_MIN_OFFSET_V = 2;
  localparam logic signed [47:0] OT_MARGIN_FIX = 48'(MARGIN_OT_C) <<< FIX_FRAC;
  localparam logic signed [47:0] OV_MARGIN_FIX = 48'(MARGIN_OV_V) <<< FIX_FRAC;
  localparam logic signed [47:0] UV_OFFSET_FIX = 48'(UV_MIN_OFFSET_V) <<< FIX_FRAC;
  localparam logic [4:0] CLAMP_EXP = 5'h1c;
  localparam int CLAMP_SHIFT = 12;
  localparam logic signed [47:0] MANT_MAX = 48'sh3ff;
  localparam logic signed [47:0] MANT_MIN = -48'sh400;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int UNIT_MS = 100;
  localparam int OT_OFF_MS = 3000;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * UNIT_MS;
  localparam logic [8:0] OT_HOLD_TICKS = 9'(OT_OFF_MS / UNIT_MS);

  typedef enum logic [3:0] {
    PFL_RUN   = 4'h1,
    PFL_RUNON = 4'h2,
    PFL_HOLD  = 4'h4,
    PFL_LATCH = 4'h8
  } pfl_prot_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pfl_cmd_s;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] data;
  } pfl_rsp_s;

  typedef struct packed {
    logic [15:0] iout;
    logic [15:0] temp;
    logic [15:0] vin;
  } pfl_meas_s;

  typedef struct packed {
    logic [15:0] oc_warn;
    logic [15:0] ot_fault;
    logic [7:0]  ot_act;
    logic [15:0] ot_warn;
    logic [15:0] ov_fault;
    logic [7:0]  ov_act;
    logic [15:0] ov_warn;
    logic [15:0] uv_warn;
    logic [15:0] uv_fault;
  } pfl_limits_s;

  typedef struct packed {
    pfl_limits_s lim;
    pfl_rsp_s    rsp;
  } pfl_regs_s;

  typedef struct packed {
    pfl_prot_e            state;
    logic [1:0]           cause;
    logic [7:0]           act;
    logic [6:0]           retries;
    logic [8:0]           ticks;
    logic [31:0]          pre;
    logic [15:0]          temp;
    logic [15:0]          vin;
    logic [NUM_FLAGS-1:0] flags;
    logic                 alert_n;
    logic                 out_en;
  } pfl_mon_s;

  // linear11 to signed fixed point; exponent+16 is the exponent with its sign bit flipped
  function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
    logic signed [47:0] m;
    m = {{37{v[10]}}, v[10:0]};
    return m <<< {~v[15], v[14:11]};
  endfunction

  function automatic logic reg_known(input logic [7:0] c);
    return c == OFS_OC_WARN || c == OFS_OT_FAULT || c == OFS_OT_ACT || c == OFS_OT_WARN ||
           c == OFS_OV_FAULT || c == OFS_OV_ACT || c == OFS_OV_WARN || c == OFS_UV_WARN ||
           c == OFS_UV_FAULT;
  endfunction

  function automatic logic reg_is_word(input logic [7:0] c);
    return !(c == OFS_OT_ACT || c == OFS_OV_ACT);
  endfunction
endpackage

// File: hw/pfl_regs.sv
// limit and response register store with registered answers
`timescale 1ns/1ps
`default_nettype none
module pfl_regs (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // command and answer
  input  wire pfl_pkg::pfl_cmd_s    cmd,
  output var  pfl_pkg::pfl_rsp_s    rsp,
  // stored limits
  output var  pfl_pkg::pfl_limits_s lim
);
  localparam pfl_pkg::pfl_regs_s REGS_RST = '{
    lim: '{oc_warn: pfl_pkg::RST_HIGH_LIMIT, ot_fault: pfl_pkg::RST_HIGH_LIMIT,
           ot_act: pfl_pkg::RST_ACTION, ot_warn: pfl_pkg::RST_HIGH_LIMIT,
           ov_fault: pfl_pkg::RST_HIGH_LIMIT, ov_act: pfl_pkg::RST_ACTION,
           ov_warn: pfl_pkg::RST_HIGH_LIMIT, uv_warn: pfl_pkg::RST_LOW_LIMIT,
           uv_fault: pfl_pkg::RST_LOW_LIMIT},
    rsp: '0};

  pfl_pkg::pfl_regs_s r_r;
  pfl_pkg::pfl_regs_s r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.rsp.valid = cmd.valid;
    r_nxt.rsp.err = 1'b0;
    r_nxt.rsp.data = 16'h0000;
    if (cmd.valid) begin
      // a wrong transfer size is refused rather than half-written
      if (!pfl_pkg::reg_known(cmd.code) || cmd.word != pfl_pkg::reg_is_word(cmd.code)) begin
        r_nxt.rsp.err = 1'b1;
      end else if (cmd.write) begin
        unique case (cmd.code)
          pfl_pkg::OFS_OC_WARN:  r_nxt.lim.oc_warn = cmd.wdata;
          pfl_pkg::OFS_OT_FAULT: r_nxt.lim.ot_fault = cmd.wdata;
          pfl_pkg::OFS_OT_ACT:   r_nxt.lim.ot_act = cmd.wdata[7:0];
          pfl_pkg::OFS_OT_WARN:  r_nxt.lim.ot_warn = cmd.wdata;
          pfl_pkg::OFS_OV_FAULT: r_nxt.lim.ov_fault = cmd.wdata;
          pfl_pkg::OFS_OV_ACT:   r_nxt.lim.ov_act = cmd.wdata[7:0];
          pfl_pkg::OFS_OV_WARN:  r_nxt.lim.ov_warn = cmd.wdata;
          pfl_pkg::OFS_UV_WARN:  r_nxt.lim.uv_warn = cmd.wdata;
          default:               r_nxt.lim.uv_fault = cmd.wdata;
        endcase
      end else begin
        unique case (cmd.code)
          pfl_pkg::OFS_OC_WARN:  r_nxt.rsp.data = r_r.lim.oc_warn;
          pfl_pkg::OFS_OT_FAULT: r_nxt.rsp.data = r_r.lim.ot_fault;
          pfl_pkg::OFS_OT_ACT:   r_nxt.rsp.data = {8'h00, r_r.lim.ot_act};
          pfl_pkg::OFS_OT_WARN:  r_nxt.rsp.data = r_r.lim.ot_warn;
          pfl_pkg::OFS_OV_FAULT: r_nxt.rsp.data = r_r.lim.ov_fault;
          pfl_pkg::OFS_OV_ACT:   r_nxt.rsp.data = {8'h00, r_r.lim.ov_act};
          pfl_pkg::OFS_OV_WARN:  r_nxt.rsp.data = r_r.lim.ov_warn;
          pfl_pkg::OFS_UV_WARN:  r_nxt.rsp.data = r_r.lim.uv_warn;
          default:               r_nxt.rsp.data = r_r.lim.uv_fault;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= REGS_RST;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign rsp = r_r.rsp;
  assign lim = r_r.lim;
endmodule
`default_nettype wire

// File: hw/pfl_monitor.sv
// fault and warning limit monitor with alert latch and protection sequencer
`timescale 1ns/1ps
`default_nettype none
module pfl_monitor #(
  parameter int unsigned TICK_CYCLES = pfl_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // command port from the bus front end
  input  wire pfl_pkg::pfl_cmd_s            cmd,
  output var  pfl_pkg::pfl_rsp_s            rsp,
  // measurements and thresholds
  input  wire pfl_pkg::pfl_meas_s           meas,
  input  wire logic                         sample_valid,
  input  wire logic                         init_done,
  input  wire logic [15:0]                  vin_on_level,
  input  wire logic [15:0]                  vin_off_level,
  // clearing events
  input  wire logic                         ctrl_pin_enable,
  input  wire logic                         operation_enable,
  input  wire logic                         ctrl_operation_cycle,
  input  wire logic                         alert_clear,
  // status and pins
  output logic                              alert_out_n,
  output logic                              output_enable,
  output logic [pfl_pkg::NUM_FLAGS-1:0]     fault_flags
);
  localparam pfl_pkg::pfl_mon_s MON_RST = '{state: pfl_pkg::PFL_RUN, alert_n: 1'b1,
                                            out_en: 1'b1, default: '0};

  pfl_pkg::pfl_mon_s    st_r;
  pfl_pkg::pfl_mon_s    st_nxt;
  pfl_pkg::pfl_limits_s lim;
  pfl_pkg::pfl_cmd_s    cmd_eff;

  logic signed [47:0] iout_fix, temp_fix, vin_fix, tlast_fix, vlast_fix;
  logic signed [47:0] ocw_fix, otf_fix, otw_fix, ovf_fix, ovw_fix, uvw_fix, uvf_fix;
  logic signed [47:0] von_fix, voff_fix, uv_eff_fix, clamp_fix, clamp_m;
  logic [10:0]        clamp_man;
  logic               uv_low, eval, clr_any, ev_ot, ev_ov, ev_uv, ev_any;
  logic [pfl_pkg::NUM_FLAGS-1:0] flag_set;
  logic [7:0]         act_sel;
  logic [1:0]         cause_sel;
  logic [6:0]         lim_retry;
  logic [8:0]         delay_units;

  assign iout_fix = pfl_pkg::lin_fix(meas.iout);
  assign temp_fix = pfl_pkg::lin_fix(meas.temp);
  assign vin_fix = pfl_pkg::lin_fix(meas.vin);
  assign tlast_fix = pfl_pkg::lin_fix(st_r.temp);
  assign vlast_fix = pfl_pkg::lin_fix(st_r.vin);
  assign ocw_fix = pfl_pkg::lin_fix(lim.oc_warn);
  assign otf_fix = pfl_pkg::lin_fix(lim.ot_fault);
  assign otw_fix = pfl_pkg::lin_fix(lim.ot_warn);
  assign ovf_fix = pfl_pkg::lin_fix(lim.ov_fault);
  assign ovw_fix = pfl_pkg::lin_fix(lim.ov_warn);
  assign uvw_fix = pfl_pkg::lin_fix(lim.uv_warn);
  assign uvf_fix = pfl_pkg::lin_fix(lim.uv_fault);
  assign von_fix = pfl_pkg::lin_fix(vin_on_level);
  assign voff_fix = pfl_pkg::lin_fix(vin_off_level);
  assign uv_eff_fix = (uvf_fix > voff_fix) ? uvf_fix : voff_fix;

  // low under-voltage fault limit is stored as turn-on minus offset, 1/16 V resolution
  assign clamp_fix = von_fix - pfl_pkg::UV_OFFSET_FIX;
  assign clamp_m = clamp_fix >>> pfl_pkg::CLAMP_SHIFT;
  assign clamp_man = (clamp_m > pfl_pkg::MANT_MAX) ? pfl_pkg::MANT_MAX[10:0] :
                     (clamp_m < pfl_pkg::MANT_MIN) ? pfl_pkg::MANT_MIN[10:0] : clamp_m[10:0];
  assign uv_low = cmd.valid && cmd.write && cmd.word && cmd.code == pfl_pkg::OFS_UV_FAULT &&
                  pfl_pkg::lin_fix(cmd.wdata) < clamp_fix;

  always_comb begin
    cmd_eff = cmd;
    if (uv_low) begin
      cmd_eff.wdata = {pfl_pkg::CLAMP_EXP, clamp_man};
    end
  end

  pfl_regs u_regs (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .cmd (cmd_eff),
    .rsp (rsp),
    .lim (lim)
  );

  // every sample meets every limit in the cycle it arrives, only after init
  assign eval = sample_valid && init_done;
  assign ev_ot = eval && temp_fix > otf_fix;
  assign ev_ov = eval && vin_fix > ovf_fix;
  assign ev_uv = eval && vin_fix < uv_eff_fix;
  assign ev_any = ev_ot || ev_ov || ev_uv;
  assign flag_set[pfl_pkg::FLG_OC_WARN] = eval && iout_fix > ocw_fix;
  assign flag_set[pfl_pkg::FLG_OT_FAULT] = ev_ot;
  assign flag_set[pfl_pkg::FLG_OT_WARN] = eval && temp_fix > otw_fix;
  assign flag_set[pfl_pkg::FLG_OV_FAULT] = ev_ov;
  assign flag_set[pfl_pkg::FLG_OV_WARN] = eval && vin_fix > ovw_fix;
  assign flag_set[pfl_pkg::FLG_UV_WARN] = eval && vin_fix < uvw_fix;
  assign flag_set[pfl_pkg::FLG_UV_FAULT] = ev_uv;

  assign clr_any = ctrl_pin_enable || operation_enable || ctrl_operation_cycle;
  // highest priority fault picks the response byte
  assign act_sel = ev_ot ? lim.ot_act : (ev_ov ? lim.ov_act : pfl_pkg::UV_ACT);
  assign cause_sel = ev_ot ? pfl_pkg::CAUSE_OT : (ev_ov ? pfl_pkg::CAUSE_OV : pfl_pkg::CAUSE_UV);
  assign lim_retry = 7'h01 << act_sel[pfl_pkg::ACT_RETRY_HI:pfl_pkg::ACT_RETRY_LO];
  assign delay_units = 9'h001 << st_r.act[pfl_pkg::ACT_DELAY_HI:0];

  always_comb begin
    st_nxt = st_r;
    if (sample_valid) begin
      st_nxt.temp = meas.temp;
      st_nxt.vin = meas.vin;
    end
    // set wins over a clear arriving in the same cycle
    st_nxt.flags = (st_r.flags & ~{pfl_pkg::NUM_FLAGS{alert_clear}}) | flag_set;
    st_nxt.alert_n = ~|st_r.flags;
    unique case (st_r.state)
      pfl_pkg::PFL_RUN: begin
        if (ev_any) begin
          st_nxt.act = act_sel;
          st_nxt.cause = cause_sel;
          unique case (act_sel[pfl_pkg::ACT_MODE_HI:pfl_pkg::ACT_MODE_LO])
            pfl_pkg::MODE_OFF: st_nxt.state = pfl_pkg::PFL_HOLD;
            pfl_pkg::MODE_HICCUP: begin
              if (act_sel[pfl_pkg::ACT_RETRY_HI:pfl_pkg::ACT_RETRY_LO] != pfl_pkg::RETRY_FOREVER &&
                  st_r.retries >= lim_retry) begin
                st_nxt.state = pfl_pkg::PFL_LATCH;
              end else begin
                st_nxt.state = pfl_pkg::PFL_HOLD;
                st_nxt.retries = (st_r.retries == 7'h7f) ? st_r.retries : st_r.retries + 7'h01;
              end
            end
            pfl_pkg::MODE_RUNON: st_nxt.state = pfl_pkg::PFL_RUNON;
            pfl_pkg::MODE_IGNORE: st_nxt.state = pfl_pkg::PFL_RUN;
          endcase
        end
      end
      pfl_pkg::PFL_RUNON: begin
        if (st_r.ticks >= delay_units) begin
          st_nxt.state = pfl_pkg::PFL_LATCH;
        end
      end
      pfl_pkg::PFL_HOLD: begin
        if (st_r.act[pfl_pkg::ACT_MODE_HI:pfl_pkg::ACT_MODE_LO] == pfl_pkg::MODE_HICCUP) begin
          if (st_r.ticks >= delay_units) begin
            st_nxt.state = pfl_pkg::PFL_RUN;
          end
        end else if (st_r.cause == pfl_pkg::CAUSE_OT) begin
          // recovery only reads samples held in the monitor, so a silent sensor keeps it off
          if (st_r.ticks >= pfl_pkg::OT_HOLD_TICKS &&
              tlast_fix <= otf_fix - pfl_pkg::OT_MARGIN_FIX) begin
            st_nxt.state = pfl_pkg::PFL_RUN;
          end
        end else if (st_r.cause == pfl_pkg::CAUSE_OV) begin
          if (vlast_fix <= ovf_fix - pfl_pkg::OV_MARGIN_FIX) begin
            st_nxt.state = pfl_pkg::PFL_RUN;
          end
        end
      end
      pfl_pkg::PFL_LATCH: st_nxt.state = pfl_pkg::PFL_LATCH;
      default: st_nxt.state = pfl_pkg::PFL_LATCH;
    endcase
    if (clr_any && st_r.state != pfl_pkg::PFL_RUN) begin
      st_nxt.state = pfl_pkg::PFL_RUN;
      st_nxt.retries = 7'h00;
    end
    // 100 ms tick counter restarts on every state change
    if (st_nxt.state != st_r.state) begin
      st_nxt.pre = 32'h0000_0000;
      st_nxt.ticks = 9'h000;
    end else if (st_r.state != pfl_pkg::PFL_RUN) begin
      if (st_r.pre == 32'(TICK_CYCLES - 1)) begin
        st_nxt.pre = 32'h0000_0000;
        st_nxt.ticks = (st_r.ticks == 9'h1ff) ? st_r.ticks : st_r.ticks + 9'h001;
      end else begin
        st_nxt.pre = st_r.pre + 32'h0000_0001;
      end
    end
    st_nxt.out_en = st_nxt.state == pfl_pkg::PFL_RUN || st_nxt.state == pfl_pkg::PFL_RUNON;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= MON_RST; // input power cycle clears the latch as well
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign alert_out_n = st_r.alert_n;
  assign output_enable = st_r.out_en;
  assign fault_flags = st_r.flags;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_hiccup_spent;
    ce && st_r.state == pfl_pkg::PFL_RUN && ev_any && !clr_any &&
    act_sel[pfl_pkg::ACT_MODE_HI:pfl_pkg::ACT_MODE_LO] == pfl_pkg::MODE_HICCUP &&
    act_sel[pfl_pkg::ACT_RETRY_HI:pfl_pkg::ACT_RETRY_LO] != pfl_pkg::RETRY_FOREVER &&
    st_r.retries >= lim_retry;
  endsequence
  sequence s_latched_off;
    st_r.state == pfl_pkg::PFL_LATCH && !output_enable;
  endsequence
  property p_retry_spent;
    s_hiccup_spent |=> s_latched_off;
  endproperty

  chk_alert_after_flag: assert property ((ce && |st_r.flags) |=> !alert_out_n)
    else $error("alert not low after a latched flag");
  chk_flag_sticky: assert property ((ce && st_r.flags[pfl_pkg::FLG_OT_FAULT] && !alert_clear)
                                    |=> fault_flags[pfl_pkg::FLG_OT_FAULT])
    else $error("temperature fault flag dropped without clear");
  chk_no_eval_init: assert property ((ce && !init_done && !alert_clear)
                                     |=> fault_flags == $past(fault_flags))
    else $error("flags moved before initialization");
  chk_ot_hold_time: assert property ((ce && st_r.state == pfl_pkg::PFL_HOLD && !clr_any &&
                                      st_r.cause == pfl_pkg::CAUSE_OT &&
                                      st_r.act[7:6] == pfl_pkg::MODE_OFF &&
                                      st_nxt.state == pfl_pkg::PFL_RUN)
                                     |-> st_r.ticks >= pfl_pkg::OT_HOLD_TICKS)
    else $error("temperature shutdown ended early");
  chk_clear_restarts: assert property ((ce && clr_any && !output_enable)
                                       |=> output_enable)
    else $error("clear event did not restore output");
  chk_warn_no_off: assert property ((ce && st_r.state == pfl_pkg::PFL_RUN && !ev_any &&
                                     flag_set[pfl_pkg::FLG_OT_WARN]) |=> output_enable)
    else $error("warning turned the output off");
  chk_ov_turn_off: assert property ((ce && st_r.state == pfl_pkg::PFL_RUN && ev_ov && !ev_ot &&
                                     !clr_any && lim.ov_act[7:6] == pfl_pkg::MODE_OFF)
                                    |=> !output_enable ##0 st_r.state == pfl_pkg::PFL_HOLD)
    else $error("over-voltage did not turn output off");
  chk_uv_clamp: assert property ((ce && uv_low) |=> lim.uv_fault == $past(cmd_eff.wdata) &&
                                 pfl_pkg::lin_fix(lim.uv_fault) > $past(pfl_pkg::lin_fix(cmd.wdata)))
    else $error("low under-voltage limit not raised");
  chk_uv_effective: assert property ((ce && eval && vin_fix < voff_fix)
                                     |=> fault_flags[pfl_pkg::FLG_UV_FAULT])
    else $error("turn-off threshold not used as under-voltage point");
  chk_size_refused: assert property ((ce && cmd.valid &&
                                      cmd.word != pfl_pkg::reg_is_word(cmd.code))
                                     |=> rsp.valid && rsp.err)
    else $error("wrong transfer size not refused");
  chk_retry_spent: assert property (p_retry_spent)
    else $error("hiccup retries not limited");
  chk_runon_delay: assert property ((ce && st_r.state == pfl_pkg::PFL_RUNON && !clr_any &&
                                     st_nxt.state == pfl_pkg::PFL_LATCH)
                                    |-> st_r.ticks >= delay_units)
    else $error("run-on ended before its delay");
endmodule
`default_nettype wire

// File: tb/pfl_host_model.sv
// host controller model driving the register command port
`timescale 1ns/1ps
`default_nettype none
module pfl_host_model (
  // clock
  input  wire logic              clk,
  // command and answer
  output var  pfl_pkg::pfl_cmd_s cmd,
  input  wire pfl_pkg::pfl_rsp_s rsp
);
  initial begin
    cmd = '0;
  end
  // released lines flip so a stale value never passes for a new one
  task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] rd, output logic err);
    @(posedge clk);
    cmd <= '{valid: 1'b1, write: w, word: wd, code: c, wdata: d};
    @(posedge clk);
    cmd <= '{valid: 1'b0, write: ~w, word: ~wd, code: ~c, wdata: ~d};
    #1;
    rd = rsp.data;
    err = rsp.valid ? rsp.err : 1'bx;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench of the fault limit monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0]  CD [9] = '{8'h4a, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59};
  localparam logic [15:0] WV [9] = '{16'h0014, 16'h0064, 16'hffc0, 16'h005a, 16'h0032,
                                     16'h00c0, 16'h0031, 16'h002f, 16'h0000};
  localparam logic [15:0] EV [9] = '{16'h0014, 16'h0064, 16'h00c0, 16'h005a, 16'h0032,
                                     16'h00c0, 16'h0031, 16'h002f, 16'he2b0};
  logic               clk;
  logic               rst;
  pfl_pkg::pfl_cmd_s  cmd;
  pfl_pkg::pfl_rsp_s  rsp;
  pfl_pkg::pfl_meas_s meas;
  logic               sv;
  logic               init_done;
  logic [15:0]        voff;
  logic [2:0]         clr;
  logic               aclr;
  logic               alert_n;
  logic               oen;
  logic [6:0]         flags;
  logic [15:0]        rd;
  logic               err;
  int                 error_cnt;
  int                 check_count;
  int                 cycles;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // tick shortened so the 3 s hold is 120 clocks
  pfl_monitor #(.TICK_CYCLES(4)) u_pfl_monitor (
    .clk(clk), .rst(rst), .ce(1'b1), .cmd(cmd), .rsp(rsp), .meas(meas), .sample_valid(sv),
    .init_done(init_done), .vin_on_level(16'h002d), .vin_off_level(voff),
    .ctrl_pin_enable(clr[0]), .operation_enable(clr[1]), .ctrl_operation_cycle(clr[2]),
    .alert_clear(aclr), .alert_out_n(alert_n), .output_enable(oen), .fault_flags(flags));
  pfl_host_model u_pfl_host_model (.clk(clk), .cmd(cmd), .rsp(rsp));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d,
                    input logic ee);
    u_pfl_host_model.xfer(w, wd, c, d, rd, err);
    check(16'(err), 16'(ee));
  endtask
  task automatic smp(input logic [15:0] i, input logic [15:0] t, input logic [15:0] v);
    @(posedge clk);
    meas <= '{iout: i, temp: t, vin: v};
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic clr_alert();
    @(posedge clk);
    aclr <= 1'b1;
    @(posedge clk);
    aclr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(16'(flags), 16'h0000);
    check(16'(alert_n), 16'h0001);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    meas = '0;
    sv = 1'b0;
    init_done = 1'b0;
    voff = 16'h0000;
    clr = 3'h0;
    aclr = 1'b0;
    error_cnt = 0;
    check_count = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    xf(1'b0, 1'b1, 8'h4a, 16'h0000, 1'b0);
    check(rd, 16'h7bff);
    xf(1'b0, 1'b0, 8'h50, 16'h0000, 1'b0);
    check(rd, 16'h0000);
    xf(1'b0, 1'b1, 8'h50, 16'h0000, 1'b1);
    xf(1'b1, 1'b0, 8'h4a, 16'h0014, 1'b1);
    xf(1'b0, 1'b1, 8'h52, 16'h0000, 1'b1);
    for (int k = 0; k < 9; k++) begin
      xf(1'b1, k != 2 && k != 5, CD[k], WV[k], 1'b0);
      xf(1'b0, k != 2 && k != 5, CD[k], 16'h0000, 1'b0);
      check(rd, EV[k]);
    end
    // limits still ignored while initialization runs
    smp(16'h0015, 16'h0065, 16'h0030);
    check(16'(flags), 16'h0000);
    check(16'(alert_n), 16'h0001);
    @(posedge clk);
    init_done <= 1'b1;
    smp(16'h0015, 16'h0065, 16'h0030);
    check(16'(flags), 16'h0007);
    check(16'(alert_n), 16'h0000);
    check(16'(oen), 16'h0000);
    smp(16'h0000, 16'h005f, 16'h0030);
    repeat (100) @(posedge clk);
    #1;
    check(16'(oen), 16'h0000);
    repeat (30) @(posedge clk);
    #1;
    check(16'(oen), 16'h0001);
    clr_alert();
    smp(16'h0000, 16'h0020, 16'h0033);
    check(16'(flags), 16'h0018);
    check(16'(oen), 16'h0000);
    smp(16'h0000, 16'h0020, 16'h002e);
    check(16'(oen), 16'h0000);
    smp(16'h0000, 16'h0020, 16'h002d);
    check(16'(oen), 16'h0001);
    check(16'(flags), 16'h0038);
    // turn-off level above the clamped fault limit decides the trip
    @(posedge clk);
    voff <= 16'h002e;
    for (int k = 0; k < 3; k++) begin
      clr_alert();
      smp(16'h0000, 16'h0020, 16'h002d);
      check(16'(flags), 16'h0060);
      check(16'(oen), 16'h0000);
      @(posedge clk);
      clr[k] <= 1'b1;
      @(posedge clk);
      clr <= 3'h0;
      #1;
      check(16'(oen), 16'h0001);
    end
    // run-on keeps the output one unit, then latches off
    xf(1'b1, 1'b0, 8'h50, 16'h0040, 1'b0);
    smp(16'h0000, 16'h0065, 16'h0030);
    check(16'(oen), 16'h0001);
    repeat (3) @(posedge clk);
    #1;
    check(16'(oen), 16'h0000);
    @(posedge clk);
    clr[1] <= 1'b1;
    @(posedge clk);
    clr <= 3'h0;
    // hiccup with a single attempt: first trip restarts, second latches
    xf(1'b1, 1'b0, 8'h50, 16'h0080, 1'b0);
    for (int k = 0; k < 2; k++) begin
      smp(16'h0000, 16'h0065, 16'h0030);
      check(16'(oen), 16'h0000);
      repeat (3) @(posedge clk);
      #1;
      check(16'(oen), 16'(k == 0));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
